// *** common/pwm_timing_consts.svh ***
// Purpose: shared constants for the power stage waveform timing core
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef PWM_TIMING_CONSTS_SVH
`define PWM_TIMING_CONSTS_SVH

// ****************************************
// widths and field positions
// ****************************************
`define PWM_CMP_W        12
`define PWM_CNT_W        13
`define PWM_RB_W         16
`define PWM_FRAC_MSB     15
`define PWM_FRAC_LSB     12
`define PWM_FRAC_W       4
`define PWM_OCFG_W       8
`define PWM_MTX_W        4

// ****************************************
// write selects of the buffered registers
// ****************************************
`define PWM_SEL_SET_A    3'h0
`define PWM_SEL_RESET_A  3'h1
`define PWM_SEL_SET_B    3'h2
`define PWM_SEL_RESET_B  3'h3
`define PWM_SEL_OCFG     3'h4
`define PWM_SEL_MTX      3'h5

// ****************************************
// reset values
// ****************************************
`define PWM_RST_CMP      12'h000
`define PWM_RST_RB       16'h0000
`define PWM_RST_OCFG     8'h00
`define PWM_RST_MTX      4'h0
`define PWM_RST_FRAME    4'h0

`endif

// *** common/pwm_timing_pkg.sv ***
// Purpose: types shared by the waveform timing core
// Assumes: nothing
// Notes:   constants live in the header
package pwm_timing_pkg;

   // ****************************************
   // ramp modes
   // ****************************************
   typedef enum logic [1:0]
   {
      RAMP_TWO    = 2'h0,
      RAMP_ONE    = 2'h1,
      RAMP_CENTER = 2'h2
   } ramp_mode_e;

   // ****************************************
   // sequencer phases, gray along idle, a, b
   // ****************************************
   typedef enum logic [1:0]
   {
      PH_IDLE = 2'h0,
      PH_A    = 2'h1,
      PH_B    = 2'h3
   } phase_e;

endpackage : pwm_timing_pkg

// *** hdl/pwm_shadow_reg.sv ***
// Purpose: one buffered register with a working copy loaded on transfer
// Assumes: write and transfer are synchronous to clk
// Notes:   a write in the transfer cycle reaches the buffer, not the copy
`timescale 1ns/1ps
`default_nettype none

module pwm_shadow_reg #(
   parameter int          WIDTH = 12,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
)(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // software side
   input  wire logic             wr,
   input  wire logic [WIDTH-1:0] wr_data,
   // transfer strobe
   input  wire logic             xfer,
   // working value
   output logic      [WIDTH-1:0] working
);

   logic [WIDTH-1:0] buffered;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         buffered <= RESET_VALUE;
         working  <= RESET_VALUE;
      end
      else if (ce)
      begin
         if (wr)
            buffered <= wr_data;
         if (xfer)
            working <= buffered;
      end
   end

endmodule : pwm_shadow_reg

`default_nettype wire

// *** hdl/pwm_frame_pattern.sv ***
// Purpose: decides whether the current cycle of a 16-cycle frame is stretched
// Assumes: frame position advances once per cycle
// Notes:   bit-reversed position ranks the cycles, spreading them evenly
`timescale 1ns/1ps
`default_nettype none

module pwm_frame_pattern #(
   parameter int FRAC_W = 4
)(
   // frame position and divider
   input  wire logic [FRAC_W-1:0] frame_pos,
   input  wire logic [FRAC_W-1:0] divider,
   // result
   output logic                   stretch
);

   logic [FRAC_W-1:0] rank;

   // rank 0,8,4,12.. gives cycle 0 for d=1, 0 and 8 for d=2, even ones for d=8
   always_comb
   begin
      for (int i = 0; i < FRAC_W; i++)
         rank[i] = frame_pos[FRAC_W-1-i];
   end

   assign stretch = (rank < divider); // RQ19 RQ23

endmodule : pwm_frame_pattern

`default_nettype wire

// *** hdl/pwm_ramp_timing.sv ***
// Purpose: waveform timing core of a two-output power stage controller
// Assumes: all inputs synchronous to clk; outputs active high
// Notes:   outputs are registered, one clock behind the sequencer
//
// Overview of operation
// [RQ1] two-ramp: part A period, then part B
// [RQ2] two-ramp on-time is reset minus set
// [RQ3] two-ramp dead-time is set plus one
// [RQ4] one-ramp: shared ramp, outputs may overlap
// [RQ5] one-ramp on-times and dead-times from compares
// [RQ6] centered: pulses centred, on-times doubled
// [RQ7] centered dead-time and cycle length doubled
// [RQ8] centered ignores reset_a_compare for outputs
// [RQ9] fifty percent copies part B into A
// [RQ10] new values applied together at cycle end
// [RQ11] software may halt, reload, restart
// [RQ12] auto latch transfers only after reset_b write
// [RQ13] auto latch change effective after next cycle
// [RQ14] lock bit blocks transfer until cleared
// [RQ15] sync covers config, matrix, four compares
// [RQ16] auto latch prevails over lock bit
// [RQ17] enhanced: 16-cycle frames, divider bits 15:12
// [RQ18] timing values are twelve bits wide
// [RQ19] d cycles stretched, spread evenly
// [RQ20] stretch adds one count to part A
// [RQ21] normal cycle is sum of four times
// [RQ22] new set loaded at top of last ramp; centered mode loads it at the bottom of the down ramp
// [RQ23] frame counter wraps, zero divider stretches none
`timescale 1ns/1ps
`default_nettype none

`include "pwm_timing_consts.svh"

module pwm_ramp_timing
   import pwm_timing_pkg::*;
#(
   parameter int CMP_W = `PWM_CMP_W,
   parameter int CNT_W = `PWM_CNT_W
)(
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   input  wire logic                    ce,
   // buffered register writes
   input  wire logic                    wr_en,
   input  wire logic [2:0]              wr_sel,
   input  wire logic [`PWM_RB_W-1:0]    wr_data,
   // configuration and control
   input  wire logic                    run,
   input  wire logic [1:0]              ramp_mode,
   input  wire logic                    fifty_percent,
   input  wire logic                    enhanced_en,
   input  wire logic                    lock,
   input  wire logic                    auto_update_latch,
   // power stage outputs
   output logic                         output_a,
   output logic                         output_b,
   // status
   output logic                         cycle_end,
   output logic [`PWM_FRAC_W-1:0]       frame_pos,
   output logic                         auto_latch_active,
   output logic                         update_pending,
   output logic [`PWM_OCFG_W-1:0]       sync_output_config,
   output logic [`PWM_MTX_W-1:0]        output_matrix_config
);

   // ****************************************
   // buffered and working registers
   // ****************************************
   logic                    xfer;
   logic [CMP_W-1:0]        w_set_a;
   logic [CMP_W-1:0]        w_reset_a;
   logic [CMP_W-1:0]        w_set_b;
   logic [`PWM_RB_W-1:0]    w_reset_b;

   wire  wr_set_a   = wr_en && (wr_sel == `PWM_SEL_SET_A);
   wire  wr_reset_a = wr_en && (wr_sel == `PWM_SEL_RESET_A);
   wire  wr_set_b   = wr_en && (wr_sel == `PWM_SEL_SET_B);
   wire  wr_reset_b = wr_en && (wr_sel == `PWM_SEL_RESET_B);
   wire  wr_ocfg    = wr_en && (wr_sel == `PWM_SEL_OCFG);
   wire  wr_mtx     = wr_en && (wr_sel == `PWM_SEL_MTX);
   wire  wr_cmp     = wr_set_a || wr_reset_a || wr_set_b || wr_reset_b;

   // every synchronised register shares the one transfer strobe
   pwm_shadow_reg #(.WIDTH(CMP_W), .RESET_VALUE(`PWM_RST_CMP)) u_set_a ( // RQ15
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_set_a),
      .wr_data (wr_data[CMP_W-1:0]),
      .xfer    (xfer),
      .working (w_set_a)
   );

   pwm_shadow_reg #(.WIDTH(CMP_W), .RESET_VALUE(`PWM_RST_CMP)) u_reset_a (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_reset_a),
      .wr_data (wr_data[CMP_W-1:0]),
      .xfer    (xfer),
      .working (w_reset_a)
   );

   pwm_shadow_reg #(.WIDTH(CMP_W), .RESET_VALUE(`PWM_RST_CMP)) u_set_b (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_set_b),
      .wr_data (wr_data[CMP_W-1:0]),
      .xfer    (xfer),
      .working (w_set_b)
   );

   pwm_shadow_reg #(.WIDTH(`PWM_RB_W), .RESET_VALUE(`PWM_RST_RB)) u_reset_b (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_reset_b),
      .wr_data (wr_data),
      .xfer    (xfer),
      .working (w_reset_b)
   );

   pwm_shadow_reg #(.WIDTH(`PWM_OCFG_W), .RESET_VALUE(`PWM_RST_OCFG)) u_ocfg ( // RQ15
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_ocfg),
      .wr_data (wr_data[`PWM_OCFG_W-1:0]),
      .xfer    (xfer),
      .working (sync_output_config)
   );

   pwm_shadow_reg #(.WIDTH(`PWM_MTX_W), .RESET_VALUE(`PWM_RST_MTX)) u_mtx (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .wr      (wr_mtx),
      .wr_data (wr_data[`PWM_MTX_W-1:0]),
      .xfer    (xfer),
      .working (output_matrix_config)
   );

   // ****************************************
   // effective timing values
   // ****************************************
   wire [CMP_W-1:0]       e_set_b   = w_set_b; // RQ18
   wire [CMP_W-1:0]       e_reset_b = w_reset_b[CMP_W-1:0];
   wire [CMP_W-1:0]       e_set_a   = fifty_percent ? w_set_b : w_set_a; // RQ9
   wire [CMP_W-1:0]       e_reset_a = fifty_percent ? e_reset_b : w_reset_a; // RQ9
   wire [`PWM_FRAC_W-1:0] divider   = w_reset_b[`PWM_FRAC_MSB:`PWM_FRAC_LSB]; // RQ17

   // ****************************************
   // frame stretch
   // ****************************************
   logic pattern_hit;

   pwm_frame_pattern #(.FRAC_W(`PWM_FRAC_W)) u_pattern (
      .frame_pos (frame_pos),
      .divider   (divider),
      .stretch   (pattern_hit)
   );

   // normal mode never stretches, so the cycle is the plain sum
   wire             stretch = enhanced_en && pattern_hit; // RQ20 RQ21
   wire [CNT_W-1:0] s_cnt   = {{(CNT_W-1){1'b0}}, stretch};

   wire [CNT_W-1:0] sa_x = {1'b0, e_set_a};
   wire [CNT_W-1:0] ra_x = {1'b0, e_reset_a};
   wire [CNT_W-1:0] sb_x = {1'b0, e_set_b};
   wire [CNT_W-1:0] rb_x = {1'b0, e_reset_b};

   // part A thresholds carry the extra count of a stretched cycle
   wire [CNT_W-1:0] thr_a = sa_x + s_cnt; // RQ20
   wire [CNT_W-1:0] lim_a = ra_x + s_cnt; // RQ20
   wire [CNT_W-1:0] thr_b = sb_x + s_cnt;
   wire [CNT_W-1:0] lim_b = rb_x + s_cnt;

   // ****************************************
   // sequencer state
   // ****************************************
   phase_e          phase;
   phase_e          next_phase;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic            held;
   logic            next_held;
   logic            end_now;
   logic            act_a;
   logic            act_b;

   wire ramp_mode_e mode     = ramp_mode_e'(ramp_mode);
   wire             at_lim_a = (cnt == lim_a);
   wire             at_rb    = (cnt == rb_x);
   wire             at_zero  = (cnt == {CNT_W{1'b0}});

   always_comb
   begin
      next_phase = phase;
      next_cnt   = cnt + 1'b1;
      next_held  = 1'b0;
      end_now    = 1'b0;
      act_a      = 1'b0;
      act_b      = 1'b0;
      case (phase)
         PH_IDLE:
         begin
            // halted: restart always opens a fresh cycle at count zero
            next_cnt = '0; // RQ11
            if (run)
               next_phase = PH_A;
         end
         PH_A:
         begin
            case (mode)
               RAMP_ONE:
               begin
                  // one shared ramp, both outputs may be active together
                  act_a = (cnt > thr_a) && (cnt <= lim_a); // RQ4 RQ5
                  act_b = (cnt > thr_b) && (cnt <= lim_b); // RQ4 RQ5
                  if (cnt == lim_b)
                  begin
                     end_now  = 1'b1;
                     next_cnt = '0;
                  end
               end
               RAMP_CENTER:
               begin
                  // up ramp; reset_a_compare plays no part here
                  act_a = (cnt < sa_x); // RQ6 RQ8
                  act_b = (cnt >= sb_x); // RQ6 RQ7
                  if (at_rb)
                  begin
                     next_phase = PH_B;
                     next_cnt   = cnt;
                  end
               end
               default:
               begin
                  // part A period: set_a+1 dead counts, then on counts
                  act_a = (cnt > thr_a); // RQ1 RQ2 RQ3
                  if (at_lim_a)
                  begin
                     next_phase = PH_B; // RQ1
                     next_cnt   = '0;
                  end
               end
            endcase
         end
         PH_B:
         begin
            if (mode == RAMP_CENTER)
            begin
               act_a = (cnt < sa_x); // RQ6
               act_b = (cnt >= sb_x); // RQ6 RQ7
               next_cnt = cnt - 1'b1;
               if (at_zero)
               begin
                  next_cnt = '0;
                  if (stretch && !held)
                     next_held = 1'b1; // RQ20
                  else
                  begin
                     end_now    = 1'b1;
                     next_phase = PH_A;
                  end
               end
            end
            else
            begin
               act_b = (cnt > sb_x); // RQ2 RQ3
               if (at_rb)
               begin
                  end_now    = 1'b1;
                  next_phase = PH_A;
                  next_cnt   = '0;
               end
            end
         end
         default:
         begin
            next_phase = PH_IDLE;
            next_cnt   = '0;
         end
      endcase
      // leaving a mode mid-cycle is not supported; halt drops to idle
      if (!run)
      begin
         next_phase = PH_IDLE;
         next_cnt   = '0;
         next_held  = 1'b0;
         end_now    = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase <= PH_IDLE;
         cnt   <= '0;
         held  <= 1'b0;
      end
      else if (ce)
      begin
         phase <= next_phase;
         cnt   <= next_cnt;
         held  <= next_held;
      end
   end

   // ****************************************
   // update synchronisation
   // ****************************************
   logic rb_last;
   logic next_rb_last;

   // auto latch prevails; otherwise the lock bit gates the transfer
   wire update_ok = auto_latch_active ? rb_last : !lock; // RQ12 RQ14 RQ16
   // end of cycle is the top of the last ramp, except in centered mode where it is the bottom of the down ramp
   assign xfer = (end_now || !run) && update_ok; // RQ10 RQ11 RQ22

   // a reset_b write in the transfer cycle is kept for the next one
   always_comb
   begin
      next_rb_last = rb_last;
      if (xfer)
         next_rb_last = 1'b0;
      if (wr_cmp)
         next_rb_last = wr_reset_b; // RQ12
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rb_last           <= 1'b0;
         auto_latch_active <= 1'b0;
      end
      else if (ce)
      begin
         rb_last <= next_rb_last;
         if (end_now)
            auto_latch_active <= auto_update_latch; // RQ13
      end
   end

   assign update_pending = rb_last;

   // ****************************************
   // frame position and outputs
   // ****************************************
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         frame_pos <= `PWM_RST_FRAME;
         output_a  <= 1'b0;
         output_b  <= 1'b0;
         cycle_end <= 1'b0;
      end
      else if (ce)
      begin
         if (!run)
            frame_pos <= `PWM_RST_FRAME;
         else if (end_now)
            frame_pos <= frame_pos + 1'b1; // RQ17 RQ23
         output_a  <= act_a;
         output_b  <= act_b;
         cycle_end <= end_now;
      end
   end

endmodule : pwm_ramp_timing

`default_nettype wire

// *** verif/pwm_ramp_timing_monitor.sv ***
// Purpose: port checker for the waveform timing core
// Assumes: ce held high; mode changes only while halted
// Notes:   bound to every instance of the core
`timescale 1ns/1ps
`default_nettype none

module pwm_ramp_timing_monitor (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // control
   input  wire logic       run,
   input  wire logic [1:0] ramp_mode,
   input  wire logic       lock,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_sel,
   // outputs and status
   input  wire logic       output_a,
   input  wire logic       output_b,
   input  wire logic       cycle_end,
   input  wire logic [3:0] frame_pos,
   input  wire logic       auto_latch_active,
   input  wire logic       update_pending,
   input  wire logic [7:0] sync_output_config,
   input  wire logic [3:0] output_matrix_config
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   wire two_ramp = (ramp_mode == 2'h0);
   // a compare write other than reset_b drops the pending flag at once
   wire cmp_wr   = wr_en && (wr_sel < 3'h3);

   // ****************************************
   // sequences and properties
   // ****************************************
   sequence s_halt;
      !run ##1 !run;
   endsequence
   sequence s_locked;
      lock && !auto_latch_active;
   endsequence
   property p_halt;
      s_halt |=> !output_a && !output_b && frame_pos == 4'h0;
   endproperty
   property p_lock_hold;
      s_locked |=> $stable(sync_output_config) && $stable(output_matrix_config);
   endproperty
   property p_load_at_end;
      ($changed(sync_output_config) || $changed(output_matrix_config)) && $past(run) |-> cycle_end;
   endproperty
   property p_auto_at_end;
      $changed(auto_latch_active) && $past(run) |-> cycle_end;
   endproperty
   property p_pending_clear;
      $fell(update_pending) && $past(run) && !$past(cmp_wr) |-> cycle_end || $past(cycle_end);
   endproperty
   property p_frame_step;
      $changed(frame_pos) && $past(run) |-> frame_pos == $past(frame_pos) + 4'h1 && cycle_end;
   endproperty
   property p_no_overlap;
      two_ramp && $past(two_ramp) |-> !(output_a && output_b);
   endproperty
   property p_end_pulse;
      two_ramp && cycle_end |=> !cycle_end;
   endproperty
   property p_b_end;
      two_ramp && run && $past(run) && $past(run, 2) && $fell(output_b) |-> $past(cycle_end);
   endproperty

   a_halt: assert property (p_halt) else $error("outputs active while halted");
   a_lock_hold: assert property (p_lock_hold) else $error("transfer while locked");
   a_load_at_end: assert property (p_load_at_end) else $error("transfer inside a cycle");
   a_auto_at_end: assert property (p_auto_at_end) else $error("auto latch changed mid cycle");
   a_pending_clear: assert property (p_pending_clear) else $error("pending cleared mid cycle");
   a_frame_step: assert property (p_frame_step) else $error("frame position step wrong");
   a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap in two-ramp");
   a_end_pulse: assert property (p_end_pulse) else $error("cycle end too close");
   a_b_end: assert property (p_b_end) else $error("part B not last in cycle");

endmodule : pwm_ramp_timing_monitor

bind pwm_ramp_timing pwm_ramp_timing_monitor i_mon (.clk, .rst_b, .run, .ramp_mode, .lock, .wr_en, .wr_sel, .output_a,
   .output_b, .cycle_end, .frame_pos, .auto_latch_active, .update_pending, .sync_output_config,
   .output_matrix_config);

`default_nettype wire

// *** verif/half_bridge_load.sv ***
// Purpose: load model measuring each cycle's on-times and length
// Assumes: outputs active high
// Notes:   a window runs from one cycle end pulse to the next
`timescale 1ns/1ps
`default_nettype none

module half_bridge_load (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // drive from the core
   input  wire logic       output_a,
   input  wire logic       output_b,
   input  wire logic       cycle_end,
   // last cycle measured
   output logic            res_valid,
   output logic [7:0]      res_on_a,
   output logic [7:0]      res_on_b,
   output logic [7:0]      res_period
);
   logic [7:0] cnt_a;
   logic [7:0] cnt_b;
   logic [7:0] cnt_p;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {res_valid, res_on_a, res_on_b, res_period} <= 25'h0000000;
         {cnt_a, cnt_b, cnt_p} <= 24'h000000;
      end
      else
      begin
         res_valid <= cycle_end;
         cnt_a <= cycle_end ? 8'h00 : cnt_a + 8'(output_a);
         cnt_b <= cycle_end ? 8'h00 : cnt_b + 8'(output_b);
         cnt_p <= cycle_end ? 8'h00 : cnt_p + 8'h01;
         if (cycle_end)
         begin
            res_on_a <= cnt_a + 8'(output_a);
            res_on_b <= cnt_b + 8'(output_b);
            res_period <= cnt_p + 8'h01;
         end
      end
   end
endmodule : half_bridge_load

`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the waveform timing core
// Assumes: ce tied high; compares kept small for short cycles
// Notes:   results of the first cycle after a start are not judged
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic        wr_en = 1'b0;
   logic [2:0]  wr_sel = 3'h0;
   logic [15:0] wr_data = 16'h0000;
   logic        run = 1'b0;
   logic [1:0]  ramp_mode = 2'h0;
   logic        fifty_percent = 1'b0;
   logic        enhanced_en = 1'b0;
   logic        lock = 1'b0;
   logic        auto_update_latch = 1'b0;
   logic        output_a, output_b, cycle_end, auto_latch_active, update_pending, res_valid;
   logic [3:0]  frame_pos, output_matrix_config;
   logic [7:0]  sync_output_config, res_on_a, res_on_b, res_period;
   logic [23:0] exp_q[$];
   int          n_mismatch = 0;
   int          total_checks = 0;

   pwm_ramp_timing i_dut (.clk, .rst_b, .ce, .wr_en, .wr_sel, .wr_data, .run, .ramp_mode, .fifty_percent,
      .enhanced_en, .lock, .auto_update_latch, .output_a, .output_b, .cycle_end, .frame_pos,
      .auto_latch_active, .update_pending, .sync_output_config, .output_matrix_config);
   half_bridge_load i_load (.clk, .rst_b, .output_a, .output_b, .cycle_end, .res_valid, .res_on_a,
      .res_on_b, .res_period);

   initial forever #10 clk = ~clk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] expd);
      total_checks++;
      if (seen !== expd)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, expd, seen);
      end
   endtask : chk

   task automatic end_of_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic wr(input logic [2:0] sel, input logic [15:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_sel = sel;
      wr_data = d;
   endtask : wr

   task automatic load4(input int sa, input int ra, input int sb, input int rb, input int d);
      wr(3'h0, 16'(sa));
      wr(3'h1, 16'(ra));
      wr(3'h2, 16'(sb));
      wr(3'h3, {4'(d), 12'(rb)});
   endtask : load4

   task automatic wait_end;
      repeat (300)
      begin
         @(negedge clk);
         if (cycle_end === 1'b1)
            break;
      end
      if (cycle_end !== 1'b1)
         n_mismatch++;
   endtask : wait_end

   task automatic wait_drain;
      repeat (2000)
      begin
         @(negedge clk);
         if (exp_q.size() == 0)
            break;
      end
      if (exp_q.size() != 0)
         n_mismatch++;
   endtask : wait_drain

   task automatic expect_n(input int n, input logic [23:0] e);
      repeat (n) exp_q.push_back(e);
   endtask : expect_n

   function automatic int brev(input logic [3:0] p);
      return int'({p[0], p[1], p[2], p[3]});
   endfunction : brev

   // on-time a, on-time b, cycle length
   function automatic logic [23:0] expect_of(input int m, input int sa, input int ra, input int sb,
                                              input int rb, input int s);
      case (m)
         1: return {8'(ra - sa), 8'(rb - sb), 8'(rb + 1 + s)};
         2: return {8'(2 * sa + ((sa > 0) ? s : 0)), 8'(2 * (rb - sb + 1)), 8'(2 * (rb + 1) + s)};
         default: return {8'(ra - sa), 8'(rb - sb), 8'(ra + rb + 2 + s)};
      endcase
   endfunction : expect_of

   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge clk)
      if (res_valid === 1'b1 && exp_q.size() > 0)
         chk("cycle", {res_on_a, res_on_b, res_period}, exp_q.pop_front());

   initial
   begin
      #1000000;
      n_mismatch++;
      end_of_test;
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      int sa, ra, sb, rb, d;
      void'($urandom(32'hA822));
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      chk("reset", {output_a, output_b, cycle_end, frame_pos, sync_output_config, output_matrix_config,
                    update_pending, auto_latch_active}, 24'h000000);
      // every mode, with and without fifty percent and enhanced
      for (int k = 0; k < 13; k++)
      begin
         sa = $urandom_range(5, 0);
         ra = sa + $urandom_range(5, 0);
         sb = ra + $urandom_range(5, 0);
         rb = sb + $urandom_range(5, 0);
         d = (k == 6) ? 0 : $urandom_range(15, 1);
         @(negedge clk);
         run = 1'b0;
         load4(sa, ra, sb, rb, d);
         @(negedge clk);
         wr_en = 1'b0;
         // code 3 runs as two-ramp
         ramp_mode = 2'((k == 12) ? 3 : k % 3);
         fifty_percent = 1'((k / 3) % 2);
         enhanced_en = 1'(k / 6);
         @(negedge clk);
         run = 1'b1;
         wait_end;
         repeat (2) @(negedge clk);
         for (int p = 1; p <= 32; p++)
            exp_q.push_back(expect_of(int'(ramp_mode), fifty_percent ? sb : sa, fifty_percent ? rb : ra, sb, rb,
                                      int'(enhanced_en && brev(4'(p)) < d)));
         wait_drain;
      end
      // lock holds the whole set until released
      @(negedge clk);
      run = 1'b0;
      load4(2, 6, 3, 7, 0);
      wr(3'h4, 16'h005A);
      wr(3'h5, 16'h0009);
      @(negedge clk);
      wr_en = 1'b0;
      ramp_mode = 2'h0;
      fifty_percent = 1'b0;
      enhanced_en = 1'b0;
      @(negedge clk);
      run = 1'b1;
      wait_end;
      lock = 1'b1;
      load4(1, 4, 2, 9, 0);
      wr(3'h4, 16'h00C3);
      wr(3'h5, 16'h0006);
      @(negedge clk);
      wr_en = 1'b0;
      expect_n(3, 24'h04040F);
      wait_drain;
      chk("config", {sync_output_config, output_matrix_config}, 24'h0005A9);
      lock = 1'b0;
      expect_n(1, 24'h04040F);
      expect_n(2, 24'h03070F);
      wait_drain;
      chk("config", {sync_output_config, output_matrix_config}, 24'h000C36);
      // auto latch waits for reset_b written last and overrides lock
      lock = 1'b1;
      auto_update_latch = 1'b1;
      @(negedge clk);
      chk("auto", auto_latch_active, 24'h000000);
      wait_end;
      @(negedge clk);
      chk("auto", auto_latch_active, 24'h000001);
      wr(3'h3, 16'h0005);
      wr(3'h0, 16'h0000);
      @(negedge clk);
      wr_en = 1'b0;
      chk("pending", update_pending, 24'h000000);
      expect_n(3, 24'h03070F);
      wait_drain;
      wr(3'h3, 16'h0005);
      @(negedge clk);
      wr_en = 1'b0;
      chk("pending", update_pending, 24'h000001);
      expect_n(1, 24'h03070F);
      expect_n(2, 24'h04030B);
      wait_drain;
      chk("pending", update_pending, 24'h000000);
      end_of_test;
   end
endmodule : testbench

`default_nettype wire
